// ---- logic/vih_consts.vh ----
`ifndef VIH_CONSTS_VH
`define VIH_CONSTS_VH

// register byte offsets on the register bus
`define VIH_OFF_IRQ_ENABLE   8'h00
`define VIH_OFF_EXT_ENABLE   8'h04
`define VIH_OFF_PRIORITY     8'h08
`define VIH_OFF_PEND_SET     8'h0C
`define VIH_OFF_PEND_CLR     8'h10
`define VIH_OFF_STATUS       8'h14

// field positions
`define VIH_GLOBAL_EN_BIT    7
`define VIH_STD_EN_COUNT     7
`define VIH_ST_SVC_LO_BIT    0
`define VIH_ST_SVC_HI_BIT    1
`define VIH_ST_CALL_BIT      2
`define VIH_ST_REQ_BIT       3
`define VIH_ST_ID_LSB        8

// reset values
`define VIH_RST_ENABLE       1'b0
`define VIH_RST_PRIORITY     1'b0
`define VIH_RST_PENDING      1'b0

// vector layout and timing in system clocks
`define VIH_VEC_BASE         16'h0003
`define VIH_CALL_CYCLES      3'h5

// bus responses
`define VIH_RESP_OKAY        2'b00
`define VIH_RESP_SLVERR      2'b10

`endif

// ---- logic/vih_arb.v ----
`timescale 1ns/1ns
// fixed-order arbiter: the lowest source index wins
module vih_arb #(
    parameter N  = 19,
    parameter IW = 5
) (
    input  wire [N-1:0]  req,
    output reg           any,
    output reg  [IW-1:0] idx
);
    integer i;

    // scan from the top so the lowest set index is left standing
    always @* begin
        any = 1'b0;
        idx = {IW{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[IW-1:0];
            end
        end
    end
endmodule // vih_arb

// ---- logic/vih_handler.v ----
// How it works
// - source events set pending regardless of enables
// - request only with pending, global and source enable
// - long call issued at instruction boundary, per-source vector
// - saved next address returned on return-from-irq
// - disabled sources never vector
// - some flags hardware-cleared, rest software-cleared except read-only
// - flag still set after return re-requests
// - global enable bit 7 masks every source
// - masked events stay pending until enabled; read-only flags follow the event
// - software set of pending acts as real event
// - one priority bit per source, low default
// - high preempts low; high never preempted
// - higher level first, then fixed index order
// - pending sampled and decoded every clock
// - one detect cycle, five-cycle long call
// - one instruction runs after return before call
// - worst case set by core instruction lengths
// - equal or lower waits for return plus one
// - read-only flags stopped only by global or source enable
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "vih_consts.vh"
module vih_handler #(
    parameter        N           = 19,
    parameter        ADDR_W      = 8,
    parameter [31:0] HW_CLR_MASK = 32'h0000000F,
    parameter [31:0] RO_MASK     = 32'h00018000
) (
    input  wire              core_clk,
    input  wire              reset_n,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire [N-1:0]      src_event,
    input  wire              cpu_instr_done,
    input  wire              cpu_irq_ret,
    input  wire [15:0]       cpu_next_pc,
    output wire              irq_req,
    output wire              long_call_instr,
    output wire [15:0]       vector_addr,
    output wire              call_active,
    output wire              resume_valid,
    output wire [15:0]       resume_pc
);
    localparam IW = 5;

    // bus slave state
    reg              aw_held_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg              w_held_reg;
    reg [31:0]       w_data_reg;
    reg [3:0]        w_strb_reg;
    reg              bvalid_reg;
    reg [1:0]        bresp_reg;
    reg              rvalid_reg;
    reg [31:0]       rdata_reg;
    reg [1:0]        rresp_reg;

    // handler state
    reg              global_reg;
    reg [N-1:0]      en_reg;
    reg [N-1:0]      prio_reg;
    reg [N-1:0]      pend_reg;
    reg [N-1:0]      pend_next;
    reg              cand_valid_reg;
    reg              cand_hi_reg;
    reg [IW-1:0]     cand_idx_reg;
    reg              svc_lo_reg;
    reg              svc_hi_reg;
    reg [15:0]       pc_lo_reg;
    reg [15:0]       pc_hi_reg;
    reg [IW-1:0]     last_id_reg;
    reg [2:0]        call_cnt_reg;
    reg              call_pulse_reg;
    reg [15:0]       vector_reg;
    reg              resume_valid_reg;
    reg [15:0]       resume_pc_reg;
    reg [31:0]       rd_mux;
    reg              rd_hit;

    wire [N-1:0]  eligible;
    wire [N-1:0]  hi_req;
    wire [N-1:0]  lo_req;
    wire          hi_any;
    wire          lo_any;
    wire [IW-1:0] hi_idx;
    wire [IW-1:0] lo_idx;
    wire          take_hi;
    wire          take_lo;
    wire          cand_still;
    wire          cand_allowed;
    wire          commit;
    wire          wr_fire;
    wire          wr_hit;
    wire [31:0]   wmask;
    wire [31:0]   wbits;
    wire [N-1:0]  sw_set;
    wire [N-1:0]  sw_clr;
    wire [N-1:0]  hw_clr;
    wire [N-1:0]  ro_bits;
    wire [15:0]   vec_calc;

    // write address and data are taken in either order, answered once both are held
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit  = (aw_addr_reg == `VIH_OFF_IRQ_ENABLE) || (aw_addr_reg == `VIH_OFF_EXT_ENABLE) ||
                     (aw_addr_reg == `VIH_OFF_PRIORITY) || (aw_addr_reg == `VIH_OFF_PEND_SET) ||
                     (aw_addr_reg == `VIH_OFF_PEND_CLR) || (aw_addr_reg == `VIH_OFF_STATUS);
    assign wmask   = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wbits   = w_data_reg & wmask;

    // software set counts as a genuine event; read-only flags ignore software
    assign ro_bits = RO_MASK[N-1:0];
    assign sw_set  = (wr_fire && aw_addr_reg == `VIH_OFF_PEND_SET) ?
                     (wbits[N-1:0] & ~ro_bits) : {N{1'b0}};
    assign sw_clr  = (wr_fire && aw_addr_reg == `VIH_OFF_PEND_CLR) ?
                     (wbits[N-1:0] & ~ro_bits) : {N{1'b0}};
    assign hw_clr  = commit ? (HW_CLR_MASK[N-1:0] & ({{(N-1){1'b0}}, 1'b1} << cand_idx_reg))
                            : {N{1'b0}};

    // request gating: both the global and the per-source enable must be on
    assign eligible = pend_reg & en_reg & {N{global_reg}};
    assign hi_req   = eligible & prio_reg;
    assign lo_req   = eligible & ~prio_reg;

    vih_arb #(
        .N  (N),
        .IW (IW)
    ) u_arb_hi (
        .req (hi_req),
        .any (hi_any),
        .idx (hi_idx)
    );

    vih_arb #(
        .N  (N),
        .IW (IW)
    ) u_arb_lo (
        .req (lo_req),
        .any (lo_any),
        .idx (lo_idx)
    );

    // a high request beats a low one; nothing preempts a running high routine
    assign take_hi = hi_any && !svc_hi_reg;
    assign take_lo = lo_any && !svc_hi_reg && !svc_lo_reg;

    // recheck at commit so a flag cleared during detection is not vectored
    assign cand_still   = eligible[cand_idx_reg];
    assign cand_allowed = cand_hi_reg ? !svc_hi_reg : (!svc_hi_reg && !svc_lo_reg);
    // the boundary that ends a return never commits, so one more instruction runs
    assign commit = cand_valid_reg && cand_still && cand_allowed && cpu_instr_done &&
                    !cpu_irq_ret && (call_cnt_reg == 3'h0);

    assign vec_calc = `VIH_VEC_BASE + {8'h00, cand_idx_reg, 3'b000};

    assign irq_req         = cand_valid_reg;
    assign long_call_instr = call_pulse_reg;
    assign vector_addr     = vector_reg;
    assign call_active     = (call_cnt_reg != 3'h0);
    assign resume_valid    = resume_valid_reg;
    assign resume_pc       = resume_pc_reg;

    // pending flags: set wins over any clear in the same cycle
    always @* begin
        pend_next = (pend_reg & ~(sw_clr | hw_clr)) | src_event | sw_set;
        pend_next = (pend_next & ~ro_bits) | (src_event & ro_bits);
    end

    // register read decode
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `VIH_OFF_IRQ_ENABLE: begin
                rd_mux[`VIH_GLOBAL_EN_BIT] = global_reg;
                rd_mux[`VIH_STD_EN_COUNT-1:0] = en_reg[`VIH_STD_EN_COUNT-1:0];
            end
            `VIH_OFF_EXT_ENABLE: begin
                rd_mux[N-`VIH_STD_EN_COUNT-1:0] = en_reg[N-1:`VIH_STD_EN_COUNT];
            end
            `VIH_OFF_PRIORITY: begin
                rd_mux[N-1:0] = prio_reg;
            end
            `VIH_OFF_PEND_SET, `VIH_OFF_PEND_CLR: begin
                rd_mux[N-1:0] = pend_reg;
            end
            `VIH_OFF_STATUS: begin
                rd_mux[`VIH_ST_SVC_LO_BIT] = svc_lo_reg;
                rd_mux[`VIH_ST_SVC_HI_BIT] = svc_hi_reg;
                rd_mux[`VIH_ST_CALL_BIT] = (call_cnt_reg != 3'h0);
                rd_mux[`VIH_ST_REQ_BIT] = cand_valid_reg;
                rd_mux[`VIH_ST_ID_LSB+IW-1:`VIH_ST_ID_LSB] = last_id_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // bus channels
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= {ADDR_W{1'b0}};
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `VIH_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= `VIH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? `VIH_RESP_OKAY : `VIH_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_hit ? `VIH_RESP_OKAY : `VIH_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // enable and priority registers honour byte strobes
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            global_reg <= `VIH_RST_ENABLE;
            en_reg     <= {N{`VIH_RST_ENABLE}};
            prio_reg   <= {N{`VIH_RST_PRIORITY}};
            pend_reg   <= {N{`VIH_RST_PENDING}};
        end else begin
            pend_reg <= pend_next;
            if (wr_fire && aw_addr_reg == `VIH_OFF_IRQ_ENABLE && w_strb_reg[0]) begin
                global_reg <= w_data_reg[`VIH_GLOBAL_EN_BIT];
                en_reg[`VIH_STD_EN_COUNT-1:0] <= w_data_reg[`VIH_STD_EN_COUNT-1:0];
            end
            if (wr_fire && aw_addr_reg == `VIH_OFF_EXT_ENABLE) begin
                en_reg[N-1:`VIH_STD_EN_COUNT] <=
                    (en_reg[N-1:`VIH_STD_EN_COUNT] & ~wmask[N-`VIH_STD_EN_COUNT-1:0]) |
                    wbits[N-`VIH_STD_EN_COUNT-1:0];
            end
            if (wr_fire && aw_addr_reg == `VIH_OFF_PRIORITY) begin
                prio_reg <= (prio_reg & ~wmask[N-1:0]) | wbits[N-1:0];
            end
        end
    end

    // detection stage: one cycle between a pending flag and a visible request
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cand_valid_reg <= 1'b0;
            cand_hi_reg    <= 1'b0;
            cand_idx_reg   <= {IW{1'b0}};
        end else begin
            cand_valid_reg <= take_hi || take_lo;
            cand_hi_reg    <= take_hi;
            cand_idx_reg   <= take_hi ? hi_idx : lo_idx;
        end
    end

    // service levels, saved return addresses and the long call itself
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            svc_lo_reg       <= 1'b0;
            svc_hi_reg       <= 1'b0;
            pc_lo_reg        <= 16'h0000;
            pc_hi_reg        <= 16'h0000;
            last_id_reg      <= {IW{1'b0}};
            call_cnt_reg     <= 3'h0;
            call_pulse_reg   <= 1'b0;
            vector_reg       <= 16'h0000;
            resume_valid_reg <= 1'b0;
            resume_pc_reg    <= 16'h0000;
        end else begin
            call_pulse_reg   <= commit;
            resume_valid_reg <= 1'b0;
            if (call_cnt_reg != 3'h0) begin
                call_cnt_reg <= call_cnt_reg - 3'h1;
            end
            if (commit) begin
                vector_reg   <= vec_calc;
                last_id_reg  <= cand_idx_reg;
                call_cnt_reg <= `VIH_CALL_CYCLES;
                if (cand_hi_reg) begin
                    svc_hi_reg <= 1'b1;
                    pc_hi_reg  <= cpu_next_pc;
                end else begin
                    svc_lo_reg <= 1'b1;
                    pc_lo_reg  <= cpu_next_pc;
                end
            end else if (cpu_irq_ret) begin
                // the innermost level returns first, so a preempted low resumes after
                if (svc_hi_reg) begin
                    svc_hi_reg       <= 1'b0;
                    resume_pc_reg    <= pc_hi_reg;
                    resume_valid_reg <= 1'b1;
                end else if (svc_lo_reg) begin
                    svc_lo_reg       <= 1'b0;
                    resume_pc_reg    <= pc_lo_reg;
                    resume_valid_reg <= 1'b1;
                end
            end
        end
    end
endmodule // vih_handler

// ---- dv/vih_handler_chk.sv ----
`timescale 1ns/1ns
// watches the core link and the bus answers of the handler
module vih_handler_chk #(
    parameter N = 19
) (
    input wire        core_clk,
    input wire        reset_n,
    input wire        cpu_instr_done,
    input wire        cpu_irq_ret,
    input wire        irq_req,
    input wire        long_call_instr,
    input wire [15:0] vector_addr,
    input wire        call_active,
    input wire        resume_valid,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    commit_cause_a: assert property (long_call_instr |->
        $past(irq_req) && $past(cpu_instr_done) && !$past(cpu_irq_ret) && !$past(call_active))
        else $error("long call without a committed boundary");
    call_len_a: assert property ($rose(long_call_instr) |->
        call_active [*5] ##1 !call_active)
        else $error("call phase not five clocks");
    ret_hold_a: assert property (cpu_instr_done && cpu_irq_ret |=>
        !long_call_instr)
        else $error("call issued straight after a return");
    vec_form_a: assert property (long_call_instr |->
        vector_addr[2:0] == 3'h3 && vector_addr < 16'h0003 + 16'(8 * N))
        else $error("vector address off the table");
    vec_hold_a: assert property (!long_call_instr |-> $stable(vector_addr))
        else $error("vector moved without a call");
    resume_cause_a: assert property (resume_valid |->
        $past(cpu_irq_ret) && $past(cpu_instr_done))
        else $error("resume without a return");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
endmodule // vih_handler_chk

bind vih_handler vih_handler_chk #(.N(N)) u_chk (.*);

// ---- dv/vih_cpu_model.sv ----
`timescale 1ns/1ns
// behavioural core: retires one instruction every instr_len clocks
module vih_cpu_model (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire [3:0]  instr_len,
    input  wire        ret_cmd,
    input  wire        long_call_instr,
    input  wire [15:0] vector_addr,
    input  wire        resume_valid,
    input  wire [15:0] resume_pc,
    output reg         cpu_instr_done,
    output reg         cpu_irq_ret,
    output reg  [15:0] cpu_next_pc
);
    reg [3:0] cnt_reg;
    reg       ret_pend_reg;

    // a requested return rides on the next retired instruction
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg        <= 4'h0;
            ret_pend_reg   <= 1'b0;
            cpu_instr_done <= 1'b0;
            cpu_irq_ret    <= 1'b0;
            cpu_next_pc    <= 16'h0100;
        end else begin
            cpu_instr_done <= 1'b0;
            cpu_irq_ret    <= 1'b0;
            ret_pend_reg   <= ret_pend_reg | ret_cmd;
            if (long_call_instr) begin
                cnt_reg     <= 4'h5;        // nothing retires during the call
                cpu_next_pc <= vector_addr; // routine sits at each vector
            end else if (resume_valid) begin
                cpu_next_pc <= resume_pc;
            end else if (cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end else begin
                cpu_instr_done <= 1'b1;
                cpu_irq_ret    <= ret_pend_reg;
                ret_pend_reg   <= ret_cmd;
                cnt_reg        <= instr_len - 4'h1;
                cpu_next_pc    <= cpu_next_pc + 16'h1;
            end
        end
    end
endmodule // vih_cpu_model

// ---- dv/vih_handler_tb.sv ----
`timescale 1ns/1ns
`include "vih_consts.vh"
module vih_handler_tb;
    localparam int N = 19;
    localparam logic [1:0] OK = `VIH_RESP_OKAY;
    logic        core_clk, reset_n, ret_cmd;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [N-1:0] src_event;
    logic        cpu_instr_done, cpu_irq_ret, irq_req, long_call_instr, call_active, resume_valid;
    logic [15:0] cpu_next_pc, vector_addr, resume_pc, pc_d;
    logic [3:0]  instr_len;
    logic [15:0] ret_q[$];
    int          miscompares, checks, calls, n_done, gap, n;

    vih_handler #(.N(N)) DUT (.*);
    vih_cpu_model u_cpu (.*);

    always #5 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // return addresses and retire counts seen on the core link
    always @(posedge core_clk) begin
        if (cpu_instr_done) n_done <= cpu_irq_ret ? 0 : n_done + 1;
        if (long_call_instr) begin
            calls <= calls + 1;
            gap   <= n_done;
            ret_q.push_back(pc_d);
        end
        if (resume_valid && ret_q.size() > 0)
            chk("resume_pc", ret_q.pop_back(), resume_pc);
        pc_d <= cpu_next_pc;
    end

    // both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid  <= !w;
        end
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge core_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask

    function automatic logic [15:0] vec(input int i);
        return `VIH_VEC_BASE + 16'(8 * i);
    endfunction

    task automatic wait_call(input int i);
        int t;
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (!long_call_instr && t < 200);
        chk("call_vec", {1'b1, vec(i)}, {long_call_instr, vector_addr});
    endtask

    task automatic irq_return();
        int t;
        t = 0;
        ret_cmd <= 1'b1;
        @(posedge core_clk);
        ret_cmd <= 1'b0;
        do begin
            @(posedge core_clk);
            t++;
        end while (!resume_valid && t < 200);
        chk("resumed", 1, resume_valid);
    endtask

    task automatic no_call(input int c);
        int k;
        k = calls;
        repeat (c) @(posedge core_clk);
        chk("calls", k, calls);
    endtask

    task automatic results();
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // the whole sequence needs a few hundred clocks
    initial begin
        #200000;
        miscompares++;
        results();
    end

    initial begin
        core_clk = 0;
        reset_n = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_event, ret_cmd} = '0;
        {miscompares, checks, calls, n_done, gap} = '0;
        instr_len = 4'h1;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 6; a++) axi_rd(8'(a * 4), 0, OK);
        axi_rd(8'h18, 0, `VIH_RESP_SLVERR);
        axi_wr(8'h18, 32'hFFFFFFFF, `VIH_RESP_SLVERR);
        // fastest path: a retire every clock
        axi_wr(`VIH_OFF_IRQ_ENABLE, 32'h81, OK);
        src_event <= 19'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            src_event <= '0;
            n++;
        end while (!long_call_instr && n < 50);
        chk("latency", 4, n);
        axi_rd(`VIH_OFF_PEND_SET, 0, OK);
        irq_return();
        instr_len <= 4'h2;
        // masked by the global bit, served once it returns
        axi_wr(`VIH_OFF_IRQ_ENABLE, 32'h04, OK);
        src_event <= 19'h4;
        @(posedge core_clk);
        src_event <= '0;
        axi_rd(`VIH_OFF_PEND_SET, 32'h4, OK);
        no_call(20);
        axi_wr(`VIH_OFF_IRQ_ENABLE, 32'h84, OK);
        wait_call(2);
        irq_return();
        // software-set flag left set re-enters after one instruction
        axi_wr(`VIH_OFF_IRQ_ENABLE, 32'h90, OK);
        axi_wr(`VIH_OFF_PEND_SET, 32'h10, OK);
        wait_call(4);
        axi_rd(`VIH_OFF_PEND_SET, 32'h10, OK);
        irq_return();
        wait_call(4);
        axi_wr(`VIH_OFF_PEND_CLR, 32'h10, OK);
        chk("gap", 1, gap);
        irq_return();
        no_call(20);
        // two levels: high first, no preemption of high, low preempted
        axi_wr(`VIH_OFF_PRIORITY, 32'h40, OK);
        axi_wr(`VIH_OFF_IRQ_ENABLE, 32'hE0, OK);
        axi_wr(`VIH_OFF_PEND_SET, 32'h60, OK);
        wait_call(6);
        axi_wr(`VIH_OFF_PEND_CLR, 32'h40, OK);
        no_call(20);
        // high level in service, low still waiting, last id is source 6
        axi_rd(`VIH_OFF_STATUS, 32'h00000602, OK);
        irq_return();
        wait_call(5);
        axi_wr(`VIH_OFF_PEND_SET, 32'h40, OK);
        wait_call(6);
        axi_wr(`VIH_OFF_PEND_CLR, 32'h40, OK);
        irq_return();
        no_call(20);
        axi_wr(`VIH_OFF_PEND_CLR, 32'h20, OK);
        irq_return();
        // a read-only flag is stopped only by its enable
        src_event <= 19'h08000;
        axi_wr(`VIH_OFF_PEND_CLR, 32'h8000, OK);
        axi_rd(`VIH_OFF_PEND_SET, 32'h8000, OK);
        axi_wr(`VIH_OFF_EXT_ENABLE, 32'h100, OK);
        wait_call(15);
        axi_wr(`VIH_OFF_EXT_ENABLE, 0, OK);
        irq_return();
        no_call(20);
        src_event <= '0;
        results();
    end
endmodule // vih_handler_tb
